// >>> fsp_pkg.sv
// constants and types shared by the flash self-programming sequencer
package fsp_pkg;

  // ==========================================================
  // register map, byte offsets on the wishbone slave
  localparam logic [7:0] ADDR_PTR_LO = 8'h00;
  localparam logic [7:0] ADDR_PTR_HI = 8'h04;
  localparam logic [7:0] ADDR_CTRL = 8'h08;
  localparam logic [7:0] ADDR_STAT = 8'h0C;
  localparam logic [7:0] PTR_RST = 8'h00;

  // ==========================================================
  // selfprog_control_reg fields
  localparam int CTL_ARM = 0;
  localparam int CTL_ERASE = 1;
  localparam int CTL_WRITE = 2;
  localparam int CTL_LOCK = 3;
  localparam int CTL_RWWRE = 4;
  localparam int CTL_RWWB = 6;
  localparam logic [4:0] PAT_RWWRE = 5'h11;
  localparam logic [4:0] PAT_LOCK = 5'h09;
  localparam logic [4:0] PAT_WRITE = 5'h05;
  localparam logic [4:0] PAT_ERASE = 5'h03;
  localparam logic [4:0] PAT_FILL = 5'h01;

  // status register fields
  localparam int STAT_BUSY = 0;
  localparam int STAT_RWWB = 1;
  localparam int STAT_EEBUSY = 2;
  localparam int STAT_ARM = 3;

  // ==========================================================
  // flash geometry: word-in-page in pointer bits 5..1, page above
  localparam int PAGE_WORDS = 32;
  localparam int WIDX_W = 5;
  localparam int PAGE_LSB = 6;
  localparam int PAGE_W = 16 - PAGE_LSB;
  localparam logic [WIDX_W-1:0] WIDX_LAST = 5'h1F;
  localparam logic [15:0] NO_READ_WHILE_WRITE_REGION_START = 16'h1800;

  // fuse and lock addresses in the armed lock-access window
  localparam logic [15:0] PTR_FLB = 16'h0000;
  localparam logic [15:0] PTR_LOCK = 16'h0001;
  localparam logic [15:0] PTR_EFB = 16'h0002;
  localparam logic [15:0] PTR_FHB = 16'h0003;

  // ==========================================================
  // timing
  localparam logic [2:0] LPM_WIN = 3'h3;
  localparam logic [2:0] SPM_WIN = 3'h4;
  // worked in ns so the cycle arithmetic stays inside 32 bits
  localparam int CLK_PERIOD_NS = 10;
  localparam int PROG_MIN_NS = 3700000;
  localparam int PROG_MAX_NS = 4500000;
  localparam int PROG_MIN_CYCLES = (PROG_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int PROG_MAX_CYCLES = PROG_MAX_NS / CLK_PERIOD_NS;

  typedef enum bit [1:0] {
    ST_IDLE = 2'b00,
    ST_COPY = 2'b01,
    ST_PROG = 2'b10
  } fsp_state_t;

endpackage

// >>> fsp_page_buf.sv
// temporary page buffer, one word per page entry, registered read
`timescale 1ns/1ps
module fsp_page_buf
  import fsp_pkg::*;
(
  // clock
  input wire logic clk_i,
  // write side
  input wire logic we_i,
  input wire logic [WIDX_W-1:0] waddr_i,
  input wire logic [15:0] wdata_i,
  // read side
  input wire logic [WIDX_W-1:0] raddr_i,
  output logic [15:0] rdata_o
);

  logic [15:0] mem_r [PAGE_WORDS];

  always_ff @(posedge clk_i) begin
    if (we_i) begin
      mem_r[waddr_i] <= wdata_i;
    end
    rdata_o <= mem_r[raddr_i];
  end

endmodule

// >>> fsp_top.sv
// flash self-programming sequencer: pointer, arm windows, timed erase/write
//
// The implementer's own choices: the Wishbone slave port and the placing of the registers.
`timescale 1ns/1ps
module fsp_top
  import fsp_pkg::*;
#(
  parameter int PROG_CYCLES = PROG_MIN_CYCLES
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // cpu store / load program operations
  input wire logic store_op_i,
  input wire logic [15:0] store_data_i,
  input wire logic load_op_i,
  output logic [7:0] load_data_o,
  output logic load_valid_o,
  output logic prog_busy_o,
  // eeprom and fuse storage
  input wire logic eeprom_write_busy_i,
  input wire logic [7:0] fuse_low_prog_i,
  input wire logic [7:0] fuse_high_prog_i,
  input wire logic [7:0] fuse_ext_prog_i,
  input wire logic [7:0] lock_prog_i,
  // flash array
  output logic flash_rd_en_o,
  output logic [14:0] flash_rd_addr_o,
  input wire logic [15:0] flash_rd_data_i,
  output logic flash_erase_o,
  output logic flash_write_o,
  output logic flash_lock_wr_o,
  output logic [7:0] flash_lock_data_o,
  output logic [PAGE_W-1:0] flash_page_o,
  output logic flash_word_we_o,
  output logic [WIDX_W-1:0] flash_word_idx_o,
  output logic [15:0] flash_word_data_o
);

  // ==========================================================
  // state
  fsp_state_t state_r;
  bit [19:0] prog_cnt_r;
  logic [7:0] ptr_lo_r;
  logic [7:0] ptr_hi_r;
  logic arm_r;
  logic erase_r;
  logic write_r;
  logic lock_r;
  logic rwwre_r;
  logic rww_busy_r;
  logic [2:0] win_r;
  logic [WIDX_W-1:0] copy_idx_r;
  logic copy_done_r;
  logic copy_vld_r;
  logic [WIDX_W-1:0] copy_widx_r;
  logic rd_lsb_r;
  logic rd_lsb2_r;
  logic rd_pipe_r;
  logic [15:0] buf_rdata;

  // ==========================================================
  // decode
  logic [15:0] ptr;
  logic idle;
  logic busy;
  logic wb_hit;
  logic wr_lo;
  logic wr_hi;
  logic wr_ctl;
  logic [4:0] ctl_pat;
  logic pat_ok;
  logic ctl_take;
  logic sp_take;
  logic st_erase;
  logic st_write;
  logic st_lock;
  logic st_rwwre;
  logic st_fill;
  logic ld_take;
  logic ld_fuse;
  logic ld_block;
  logic ld_flash;
  logic expire;
  logic [7:0] fuse_byte;
  logic [7:0] ctl_rd;
  logic [7:0] stat_rd;
  logic [31:0] rd_mux;
  logic prog_done;
  logic copy_last;

  assign ptr = {ptr_hi_r, ptr_lo_r};
  assign idle = (state_r == ST_IDLE);
  assign busy = !idle;
  assign wb_hit = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign wr_lo = wb_hit && wb_we_i && wb_sel_i[0] && (wb_adr_i == ADDR_PTR_LO);
  assign wr_hi = wb_hit && wb_we_i && wb_sel_i[0] && (wb_adr_i == ADDR_PTR_HI);
  assign wr_ctl = wb_hit && wb_we_i && wb_sel_i[0] && (wb_adr_i == ADDR_CTRL);
  assign ctl_pat = wb_dat_i[4:0];
  assign pat_ok = (ctl_pat == PAT_RWWRE) || (ctl_pat == PAT_LOCK) ||
                  (ctl_pat == PAT_WRITE) || (ctl_pat == PAT_ERASE) ||
                  (ctl_pat == PAT_FILL);
  // control writes are dropped while eeprom busy or a flash op runs
  assign ctl_take = wr_ctl && pat_ok && !eeprom_write_busy_i && idle && !rst_i;

  assign sp_take = store_op_i && arm_r && idle && !eeprom_write_busy_i && !rst_i;
  assign st_erase = sp_take && erase_r;
  assign st_write = sp_take && write_r;
  assign st_lock = sp_take && lock_r;
  assign st_rwwre = sp_take && rwwre_r;
  assign st_fill = sp_take && !(erase_r || write_r || lock_r || rwwre_r);

  assign ld_take = load_op_i && !rst_i;
  assign ld_fuse = ld_take && lock_r && arm_r && idle && (win_r < LPM_WIN) &&
                   !eeprom_write_busy_i;
  // read-while-write region is dark until software re-enables it
  assign ld_block = ld_take && !ld_fuse && rww_busy_r && (ptr < NO_READ_WHILE_WRITE_REGION_START);
  assign ld_flash = ld_take && !ld_fuse && !ld_block;
  assign expire = arm_r && idle && !sp_take && !ld_fuse && (win_r == SPM_WIN - 3'h1);

  // stored bits are programmed-high; programmed reads as zero
  assign fuse_byte = (ptr == PTR_FLB) ? ~fuse_low_prog_i :
                     (ptr == PTR_LOCK) ? ~lock_prog_i :
                     (ptr == PTR_EFB) ? ~fuse_ext_prog_i :
                     (ptr == PTR_FHB) ? ~fuse_high_prog_i : 8'hFF;

  assign ctl_rd = {1'b0, rww_busy_r, 1'b0, rwwre_r, lock_r, write_r, erase_r, arm_r};
  assign stat_rd = {4'h0, arm_r, eeprom_write_busy_i, rww_busy_r, busy};
  assign rd_mux = (wb_adr_i == ADDR_PTR_LO) ? {24'h000000, ptr_lo_r} :
                  (wb_adr_i == ADDR_PTR_HI) ? {24'h000000, ptr_hi_r} :
                  (wb_adr_i == ADDR_CTRL) ? {24'h000000, ctl_rd} :
                  (wb_adr_i == ADDR_STAT) ? {24'h000000, stat_rd} : 32'h00000000;

  assign prog_done = (state_r == ST_PROG) && (prog_cnt_r == 20'h00000);
  assign copy_last = flash_word_we_o && (flash_word_idx_o == WIDX_LAST);

  // ==========================================================
  // wishbone slave, one wait state, unmapped reads give zero
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
    end else begin
      wb_ack_o <= wb_hit;
      wb_dat_o <= wb_hit ? rd_mux : 32'h00000000;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ptr_lo_r <= PTR_RST;
      ptr_hi_r <= PTR_RST;
    end else begin
      if (wr_lo) begin
        ptr_lo_r <= wb_dat_i[7:0];
      end
      if (wr_hi) begin
        ptr_hi_r <= wb_dat_i[7:0];
      end
    end
  end

  // ==========================================================
  // arm bits and window timer
  // a running erase/write keeps its bits across reset so it can finish
  always_ff @(posedge clk_i) begin
    if (rst_i && idle) begin
      {arm_r, erase_r, write_r, lock_r, rwwre_r} <= 5'h00;
      win_r <= 3'h0;
    end else if (ctl_take) begin
      arm_r <= ctl_pat[CTL_ARM];
      erase_r <= ctl_pat[CTL_ERASE];
      write_r <= ctl_pat[CTL_WRITE];
      lock_r <= ctl_pat[CTL_LOCK];
      rwwre_r <= ctl_pat[CTL_RWWRE];
      win_r <= 3'h0;
    end else if (prog_done) begin
      {arm_r, erase_r, write_r, lock_r, rwwre_r} <= 5'h00;
    end else if (idle && arm_r) begin
      if (st_erase || st_write || st_lock) begin
        win_r <= 3'h0;
      end else if (sp_take || ld_fuse || expire) begin
        {arm_r, erase_r, write_r, lock_r, rwwre_r} <= 5'h00;
      end else begin
        win_r <= win_r + 3'h1;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i && idle) begin
      rww_busy_r <= 1'b0;
    end else if (st_erase || st_write) begin
      rww_busy_r <= 1'b1;
    end else if (st_rwwre) begin
      rww_busy_r <= 1'b0;
    end
  end

  // ==========================================================
  // sequencer: copy buffer to flash, then hold the timed write
  always_ff @(posedge clk_i) begin
    flash_erase_o <= 1'b0;
    flash_write_o <= 1'b0;
    flash_lock_wr_o <= 1'b0;
    if (rst_i && idle) begin
      state_r <= ST_IDLE;
      prog_cnt_r <= 20'h00000;
      flash_page_o <= '0;
      flash_lock_data_o <= 8'h00;
    end else begin
      case (state_r)
        ST_IDLE: begin
          if (st_erase || st_write) begin
            flash_page_o <= ptr[15:PAGE_LSB];
          end
          if (st_erase || st_lock) begin
            state_r <= ST_PROG;
            prog_cnt_r <= 20'(PROG_CYCLES - 1);
            flash_erase_o <= st_erase;
            flash_lock_wr_o <= st_lock;
            flash_lock_data_o <= store_data_i[7:0];
          end else if (st_write) begin
            state_r <= ST_COPY;
          end
        end
        ST_COPY: begin
          if (copy_last) begin
            state_r <= ST_PROG;
            prog_cnt_r <= 20'(PROG_CYCLES - 1);
            flash_write_o <= 1'b1;
          end
        end
        ST_PROG: begin
          if (prog_done) begin
            state_r <= ST_IDLE;
          end else begin
            prog_cnt_r <= prog_cnt_r - 20'h00001;
          end
        end
        default: begin
          state_r <= ST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (state_r != ST_COPY) begin
      copy_idx_r <= '0;
      copy_done_r <= 1'b0;
      copy_vld_r <= 1'b0;
      copy_widx_r <= '0;
    end else begin
      copy_vld_r <= !copy_done_r;
      copy_widx_r <= copy_idx_r;
      copy_idx_r <= copy_idx_r + WIDX_W'(1);
      copy_done_r <= copy_done_r || (copy_idx_r == WIDX_LAST);
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i && idle) begin
      flash_word_we_o <= 1'b0;
      flash_word_idx_o <= '0;
      flash_word_data_o <= 16'h0000;
    end else begin
      flash_word_we_o <= copy_vld_r;
      flash_word_idx_o <= copy_widx_r;
      flash_word_data_o <= buf_rdata;
    end
  end

  // pointer bit 0 is dropped when filling the buffer
  fsp_page_buf u_buf (
    .clk_i(clk_i),
    .we_i(st_fill),
    .waddr_i(ptr[PAGE_LSB-1:1]),
    .wdata_i(store_data_i),
    .raddr_i(copy_idx_r),
    .rdata_o(buf_rdata)
  );

  // ==========================================================
  // load path: fuse/lock answer next cycle, flash answer after array latency
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      flash_rd_en_o <= 1'b0;
      flash_rd_addr_o <= 15'h0000;
      rd_lsb_r <= 1'b0;
      rd_lsb2_r <= 1'b0;
      rd_pipe_r <= 1'b0;
      load_data_o <= 8'h00;
      load_valid_o <= 1'b0;
    end else begin
      flash_rd_en_o <= ld_flash;
      if (ld_flash) begin
        flash_rd_addr_o <= ptr[15:1];
        rd_lsb_r <= ptr[0];
      end
      rd_pipe_r <= flash_rd_en_o;
      rd_lsb2_r <= rd_lsb_r;
      load_valid_o <= ld_fuse || ld_block || rd_pipe_r;
      if (ld_fuse) begin
        load_data_o <= fuse_byte;
      end else if (ld_block) begin
        load_data_o <= 8'hFF;
      end else if (rd_pipe_r) begin
        load_data_o <= rd_lsb2_r ? flash_rd_data_i[15:8] : flash_rd_data_i[7:0];
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i && idle) begin
      prog_busy_o <= 1'b0;
    end else begin
      prog_busy_o <= st_erase || st_write || st_lock || (busy && !prog_done);
    end
  end

endmodule

// >>> fsp_top_asserts.sv
// checker for the flash self-programming sequencer ports
`timescale 1ns/1ps
module fsp_top_chk
  import fsp_pkg::*;
#(
  parameter int PROG_CYCLES = PROG_MIN_CYCLES
) (
  // clock, reset, bus
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_ack_o,
  // cpu side
  input wire logic store_op_i,
  input wire logic [15:0] store_data_i,
  input wire logic eeprom_write_busy_i,
  input wire logic load_valid_o,
  input wire logic [7:0] load_data_o,
  input wire logic prog_busy_o,
  // flash side
  input wire logic flash_rd_en_o,
  input wire logic [15:0] flash_rd_data_i,
  input wire logic flash_erase_o,
  input wire logic flash_write_o,
  input wire logic flash_lock_wr_o,
  input wire logic [7:0] flash_lock_data_o,
  input wire logic [PAGE_W-1:0] flash_page_o,
  input wire logic flash_word_we_o,
  input wire logic [WIDX_W-1:0] flash_word_idx_o
);
  // ==========
  // helpers
  wire logic start_w = flash_erase_o | flash_write_o | flash_lock_wr_o;
  logic [19:0] run_r;
  logic [15:0] rdq_r;
  logic [7:0] stq_r;

  // no reset: a timed op outlives rst_i, so its length count must too
  always_ff @(posedge clk_i) begin
    run_r <= start_w ? 20'h00001 : (prog_busy_o ? run_r + 20'h00001 : 20'h00000);
    rdq_r <= flash_rd_data_i;
    stq_r <= store_data_i[7:0];
  end

  // ==========
  // properties
  default clocking @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  a_ack_next: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("no ack after request");
  a_rd_valid: assert property (flash_rd_en_o |-> ##2 load_valid_o)
    else $error("flash read result late");
  a_byte_sel: assert property (load_valid_o && $past(flash_rd_en_o, 2) |->
    load_data_o == rdq_r[15:8] || load_data_o == rdq_r[7:0]) else $error("load byte wrong");
  a_prog_len: assert property ($fell(prog_busy_o) |-> run_r == PROG_CYCLES)
    else $error("timed op length wrong");
  a_page_held: assert property ($changed(flash_page_o) |->
    $past(store_op_i) && prog_busy_o && !flash_lock_wr_o)
    else $error("page moved outside op start");
  a_lock_data: assert property (flash_lock_wr_o |-> flash_lock_data_o == stq_r)
    else $error("lock data not from store word");
  a_store_cause: assert property (flash_erase_o || flash_lock_wr_o |-> $past(store_op_i))
    else $error("op started without store");
  a_ee_block: assert property (store_op_i && eeprom_write_busy_i && !prog_busy_o |=> !start_w)
    else $error("op started while eeprom busy");
  a_copy_end: assert property (flash_word_we_o && flash_word_idx_o == WIDX_LAST |->
    ##[1:2] flash_write_o) else $error("page write did not follow copy");
endmodule

bind fsp_top fsp_top_chk #(.PROG_CYCLES(PROG_CYCLES)) u_fsp_top_chk (.*);

// >>> fsp_flash_model.sv
// flash array model: word data valid only the cycle after a read
`timescale 1ns/1ps
module fsp_flash_model (
  // clock and read port
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic rd_en_i,
  input wire logic [14:0] rd_addr_i,
  output logic [15:0] rd_data_o
);
  logic [15:0] junk_r;

  // outside a read the bus churns so a late sample never looks right
  always_ff @(posedge clk_i) begin
    junk_r <= rst_i ? 16'h1D2B : {junk_r[14:0], junk_r[15]} ^ 16'h0100;
    rd_data_o <= rd_en_i ? {rd_addr_i[7:0], ~rd_addr_i[7:0]} : junk_r;
  end
endmodule

// >>> tb_fsp_top.sv
// self-checking bench for the flash self-programming sequencer
`timescale 1ns/1ps
module tb_fsp_top
  import fsp_pkg::*;
;
  localparam int PROGC = 20;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0, store_op_i = 1'b0, load_op_i = 1'b0;
  logic eeprom_write_busy_i = 1'b0;
  logic [7:0] wb_adr_i = 8'h00;
  logic [3:0] wb_sel_i = 4'hF;
  logic [31:0] wb_dat_i = 32'h0, wb_dat_o, q;
  logic [15:0] store_data_i = 16'h0, flash_rd_data_i, flash_word_data_o;
  logic [7:0] fuse_low_prog_i = 8'h12, fuse_high_prog_i = 8'hA9, fuse_ext_prog_i = 8'h05;
  logic [7:0] lock_prog_i = 8'h3C, load_data_o, flash_lock_data_o;
  logic wb_ack_o, load_valid_o, prog_busy_o, flash_rd_en_o;
  logic flash_erase_o, flash_write_o, flash_lock_wr_o, flash_word_we_o;
  logic [14:0] flash_rd_addr_o;
  logic [PAGE_W-1:0] flash_page_o;
  logic [WIDX_W-1:0] flash_word_idx_o;
  wire logic [31:0] word_w = {11'h0, flash_word_idx_o, flash_word_data_o};
  int err_count = 0;
  int check_count = 0;

  always #5 clk_i = ~clk_i;

  fsp_top #(.PROG_CYCLES(PROGC)) u_fsp_top (.*);
  fsp_flash_model u_fsp_flash_model (.clk_i(clk_i), .rst_i(rst_i), .rd_en_i(flash_rd_en_o),
    .rd_addr_i(flash_rd_addr_o), .rd_data_o(flash_rd_data_i));

  // ==========
  // shared tasks
  task automatic close_out();
    if (err_count == 0 && check_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic tmo(input string n);
    chk(n, 32'h1, 32'h0);
    close_out();
  endtask

  task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= w;
    wb_adr_i <= a;
    wb_dat_i <= d;
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 20);
    if (wb_ack_o !== 1'b1) tmo("bus ack");
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask

  task automatic rdc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    bus(a, 1'b0, 32'h0);
    chk($sformatf("reg %h", a), e, q & m);
  endtask

  task automatic setptr(input logic [15:0] p);
    bus(ADDR_PTR_LO, 1'b1, 32'(p[7:0]));
    bus(ADDR_PTR_HI, 1'b1, 32'(p[15:8]));
  endtask

  // one-cycle store or load, launched right after the current edge
  task automatic pulse(input bit st);
    store_op_i <= st;
    load_op_i <= !st;
    @(posedge clk_i);
    store_op_i <= 1'b0;
    load_op_i <= 1'b0;
  endtask

  task automatic ld(input logic [7:0] e, input string n);
    int k;
    k = 0;
    pulse(1'b0);
    while (load_valid_o !== 1'b1 && k < 8) begin
      @(posedge clk_i);
      k++;
    end
    if (k == 8) tmo(n);
    chk(n, 32'(e), 32'(load_data_o));
  endtask

  task automatic prog(input logic [4:0] c, input bit pc, input logic [31:0] pg, input int nw,
    input bit rm);
    int n;
    int k;
    n = 0;
    k = 0;
    bus(ADDR_CTRL, 1'b1, 32'(c));
    pulse(1'b1);
    while ((flash_erase_o | flash_write_o | flash_lock_wr_o) !== 1'b1 && n < 80) begin
      @(posedge clk_i);
      n++;
      if (flash_word_we_o === 1'b1) begin
        chk("copy", {11'h0, 5'(k), 16'hC000 + 16'(k)}, word_w);
        k++;
      end
    end
    if (n == 80) tmo("op start");
    chk("words", nw, k);
    if (pc) chk("page", pg, 32'(flash_page_o));
    n = 0;
    while (prog_busy_o === 1'b1 && n < 200) begin
      n++;
      @(posedge clk_i);
      if (rm) rst_i <= (n == 4 || n == 5);
    end
    if (n == 200) tmo("busy");
    chk("busy run", PROGC, n);
  endtask

  // ==========
  // scenarios
  task automatic t_reset();
    logic [7:0] al [5] = '{ADDR_PTR_LO, ADDR_PTR_HI, ADDR_CTRL, ADDR_STAT, 8'h20};
    bus(8'h20, 1'b1, 32'hFF);
    for (int i = 0; i < 5; i++) rdc(al[i], 32'hFFFFFFFF, 32'h0);
  endtask

  task automatic t_fuse();
    logic [7:0] e [4];
    e = '{~fuse_low_prog_i, ~lock_prog_i, ~fuse_ext_prog_i, ~fuse_high_prog_i};
    for (int k = 0; k < 4; k++) begin
      setptr(16'(k));
      bus(ADDR_CTRL, 1'b1, 32'(PAT_LOCK));
      ld(e[k], "fuse byte");
      rdc(ADDR_CTRL, 32'hFF, 32'h0);
    end
  endtask

  task automatic t_expire();
    setptr(16'h0203);
    bus(ADDR_CTRL, 1'b1, 32'(PAT_LOCK));
    repeat (4) @(posedge clk_i);
    rdc(ADDR_CTRL, 32'hFF, 32'h0);
    ld(8'h01, "flash byte");
  endtask

  task automatic t_block();
    logic [7:0] bad [4] = '{8'h07, 8'h02, 8'h19, 8'h10};
    eeprom_write_busy_i <= 1'b1;
    bus(ADDR_CTRL, 1'b1, 32'(PAT_ERASE));
    rdc(ADDR_CTRL, 32'hFF, 32'h0);
    rdc(ADDR_STAT, 32'hFF, 32'(1 << STAT_EEBUSY));
    eeprom_write_busy_i <= 1'b0;
    bus(ADDR_CTRL, 1'b1, 32'(PAT_ERASE));
    eeprom_write_busy_i <= 1'b1;
    pulse(1'b1);
    repeat (2) @(posedge clk_i);
    chk("busy", 32'h0, 32'(prog_busy_o));
    eeprom_write_busy_i <= 1'b0;
    for (int i = 0; i < 4; i++) begin
      bus(ADDR_CTRL, 1'b1, 32'(bad[i]));
      rdc(ADDR_CTRL, 32'hFF, 32'h0);
    end
  endtask

  task automatic t_erase();
    setptr(16'h1240);
    prog(PAT_ERASE, 1'b1, 32'h49, 0, 1'b0);
    setptr(16'h0206);
    chk("page held", 32'h49, 32'(flash_page_o));
    ld(8'hFF, "rww blocked");
    setptr(16'h1803);
    ld(8'h01, "no_read_while_write_region byte");
    bus(ADDR_CTRL, 1'b1, 32'(PAT_RWWRE));
    pulse(1'b1);
    setptr(16'h0206);
    ld(8'hFC, "rww byte");
  endtask

  task automatic t_write();
    setptr(16'h1240);
    for (int i = 0; i < 32; i++) begin
      bus(ADDR_PTR_LO, 1'b1, 32'(8'h40 + 2 * i + (i == 5)));
      bus(ADDR_CTRL, 1'b1, 32'(PAT_FILL));
      store_data_i <= 16'hC000 + 16'(i);
      pulse(1'b1);
    end
    bus(ADDR_PTR_LO, 1'b1, 32'h40);
    prog(PAT_WRITE, 1'b1, 32'h49, 32, 1'b0);
  endtask

  task automatic t_lock();
    setptr(16'h0007);
    store_data_i <= 16'h55C3;
    prog(PAT_LOCK, 1'b0, 32'h0, 0, 1'b1);
    rdc(ADDR_CTRL, 32'h1F, 32'h0);
    rdc(ADDR_PTR_LO, 32'hFF, 32'h0);
  endtask

  initial begin
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    t_reset();
    t_fuse();
    t_expire();
    t_block();
    t_erase();
    t_write();
    t_lock();
    close_out();
  end
endmodule
